// File: port_alarm_monitor.v
// alarm detection and indication for one e1/t1 tributary port
`timescale 1ns/1ps
`include "port_alarm_regs.vh"
module port_alarm_monitor #(
  parameter FLASH_CYCLES = `FLASH_CYCLES,
  parameter [3:0] SLOT_ID = 4'h0,
  parameter [1:0] PORT_ID = 2'h0
) (
  input wire clk,
  input wire reset_n,
  input wire [3:0] addr,
  input wire [31:0] wdata,
  input wire wr,
  input wire rd,
  output reg [31:0] rdata,
  input wire line_signal_valid,
  input wire frame_align_found,
  input wire ais_pattern_rx,
  input wire remote_alarm_bit,
  input wire signalling_valid,
  input wire multiframe_bit6,
  input wire signalling_all_ones,
  input wire upstream_traffic_ok,
  input wire signalling_stream_ok,
  input wire switchover_event,
  input wire boot_backup_table,
  input wire boot_default_table,
  output reg tx_ais,
  output reg tx_signalling_ais,
  output reg yellow_led,
  output reg green_led,
  output reg [1:0] ok_led,
  output reg [1:0] rx_led,
  output reg [1:0] tx_led
);
  // ==========================================================
  // input synchronisers
  // ==========================================================
  wire [11:0] pins;
  sync2 #(.WIDTH(12)) u_sync (
    .clk(clk),
    .reset_n(reset_n),
    .async_in({line_signal_valid, frame_align_found, ais_pattern_rx,
      remote_alarm_bit, signalling_valid, multiframe_bit6,
      signalling_all_ones, upstream_traffic_ok, signalling_stream_ok,
      switchover_event, boot_backup_table, boot_default_table}),
    .sync_out(pins)
  );
  wire s_line = pins[11];
  wire s_frame = pins[10];
  wire s_ais = pins[9];
  wire s_rai = pins[8];
  wire s_sig = pins[7];
  wire s_mf6 = pins[6];
  wire s_ones = pins[5];
  wire s_up = pins[4];
  wire s_sig_ok = pins[3];
  wire s_switch = pins[2];
  wire s_backup = pins[1];
  wire s_default = pins[0];
  // ==========================================================
  // registers
  // ==========================================================
  reg [31:0] control;
  reg [7:0] sys_alarm;
  reg [15:0] radio_alarm;
  reg switched_alarm;
  reg backup_alarm;
  reg default_alarm;
  reg [1:0] boot_wait;
  reg [8:0] status;
  wire boot_sample = (boot_wait == `BOOT_SETTLE);
  wire framed = control[`CTRL_FRAMED];
  // signalling slot exists only in e1 multiframe mode
  wire pcm30 = control[`CTRL_PCM30] & ~control[`CTRL_T1];
  wire loopback = control[`CTRL_LOOPBACK];
  wire cmd = wr && (addr == `ADDR_COMMAND);
  wire clr_switch = cmd && (wdata[`CMD_CLEAR_SWITCHED] ||
    wdata[`CMD_CLEAR_ALL]);
  wire clr_image = cmd && (wdata[`CMD_CLEAR_IMAGE] ||
    wdata[`CMD_CLEAR_ALL]);
  wire clr_all = cmd && wdata[`CMD_CLEAR_ALL];
  wire wr_control = wr && (addr == `ADDR_CONTROL);
  wire wr_sys = wr && (addr == `ADDR_SYS_ALARM);
  wire wr_radio = wr && (addr == `ADDR_RADIO_ALARM);
  // ==========================================================
  // alarm detection
  // ==========================================================
  reg [8:0] next_status;
  always @*
  begin
    next_status = 9'h000;
    next_status[`ST_LOS] = ~s_line;
    next_status[`ST_LOF] = framed & s_line & ~s_frame;
    next_status[`ST_AIS] = s_line & ~(framed & ~s_frame) & s_ais;
    next_status[`ST_RAI] = framed & s_line & s_rai;
    next_status[`ST_SIG_LOS] = pcm30 & s_line & ~s_sig;
    next_status[`ST_RMA] = pcm30 & s_line & s_mf6;
    next_status[`ST_SIG_AIS] = pcm30 & s_line & s_ones;
    next_status[`ST_TX_AIS] = ~s_up;
    next_status[`ST_TX_SIG_AIS] = pcm30 & ~s_sig_ok;
  end
  // ==========================================================
  // boot flag settle counter
  // ==========================================================
  // boot flags must clear the synchroniser before they are taken
  always @(posedge clk)
  begin
    if (!reset_n)
      boot_wait <= 2'h0;
    else if (boot_wait != `BOOT_DONE)
      boot_wait <= boot_wait + 2'h1;
  end
  // ==========================================================
  // switchover latch, set wins over clear
  // ==========================================================
  always @(posedge clk)
  begin
    if (!reset_n)
      switched_alarm <= 1'b0;
    else if (s_switch)
      switched_alarm <= 1'b1;
    else if (clr_switch)
      switched_alarm <= 1'b0;
  end
  // ==========================================================
  // image table latches, set wins over clear
  // ==========================================================
  always @(posedge clk)
  begin
    if (!reset_n)
    begin
      backup_alarm <= 1'b0;
      default_alarm <= 1'b0;
    end
    else
    begin
      if (boot_sample && s_default)
        default_alarm <= 1'b1;
      else if (clr_image)
        default_alarm <= 1'b0;
      // a rebuilt table outranks a backup one
      if (boot_sample && s_backup && !s_default)
        backup_alarm <= 1'b1;
      else if (clr_image)
        backup_alarm <= 1'b0;
    end
  end
  // ==========================================================
  // alarm status, cleared for one cycle by clear all
  // ==========================================================
  always @(posedge clk)
  begin
    if (!reset_n)
      status <= 9'h000;
    else if (clr_all)
      status <= 9'h000;
    else
      status <= next_status;
  end
  // ==========================================================
  // register writes
  // ==========================================================
  always @(posedge clk)
  begin
    if (!reset_n)
    begin
      control <= `CTRL_RESET;
      sys_alarm <= 8'h00;
      radio_alarm <= 16'h0000;
    end
    else
    begin
      if (wr_control)
        control <= {28'h000_0000, wdata[3:0]};
      if (wr_sys)
        sys_alarm <= wdata[7:0];
      if (wr_radio)
        radio_alarm <= wdata[15:0];
    end
  end
  // ==========================================================
  // panel colours
  // ==========================================================
  wire port_minor = |status[6:0];
  wire ok_minor = sys_alarm[0] | switched_alarm | backup_alarm |
    default_alarm | port_minor;
  wire [1:0] ok_colour;
  wire [1:0] rx_colour;
  wire [1:0] tx_colour;
  colour_pick u_ok (
    .major(sys_alarm[1]),
    .minor(ok_minor),
    .idle_colour(`COLOUR_GREEN),
    .colour(ok_colour)
  );
  colour_pick u_rx (
    .major(radio_alarm[2] | radio_alarm[3]),
    .minor(radio_alarm[0] | radio_alarm[1]),
    .idle_colour(`COLOUR_GREEN),
    .colour(rx_colour)
  );
  colour_pick u_tx (
    .major(radio_alarm[12] | radio_alarm[13]),
    .minor(|radio_alarm[11:8]),
    .idle_colour(`COLOUR_GREEN),
    .colour(tx_colour)
  );
  // ==========================================================
  // flash divider, one cycle tick per half period
  // ==========================================================
  reg [31:0] flash_count;
  reg flash_tick;
  reg flash_phase;
  always @(posedge clk)
  begin
    if (!reset_n)
    begin
      flash_count <= 32'h0000_0000;
      flash_tick <= 1'b0;
    end
    else if (flash_count >= FLASH_CYCLES - 1)
    begin
      flash_count <= 32'h0000_0000;
      flash_tick <= 1'b1;
    end
    else
    begin
      flash_count <= flash_count + 32'h0000_0001;
      flash_tick <= 1'b0;
    end
  end
  // ==========================================================
  // flash phase, toggled on each tick
  // ==========================================================
  always @(posedge clk)
  begin
    if (!reset_n)
      flash_phase <= 1'b0;
    else if (flash_tick)
      flash_phase <= ~flash_phase;
  end
  // ==========================================================
  // outputs
  // ==========================================================
  always @(posedge clk)
  begin
    if (!reset_n)
    begin
      tx_ais <= 1'b0;
      tx_signalling_ais <= 1'b0;
      yellow_led <= 1'b0;
      green_led <= 1'b0;
      ok_led <= `COLOUR_OFF;
      rx_led <= `COLOUR_OFF;
      tx_led <= `COLOUR_OFF;
    end
    else
    begin
      // taken ahead of the status clear so ais never blinks off
      tx_ais <= next_status[`ST_TX_AIS];
      tx_signalling_ais <= next_status[`ST_TX_SIG_AIS];
      yellow_led <= status[`ST_LOS] | status[`ST_AIS] |
        status[`ST_LOF];
      green_led <= loopback ? flash_phase : 1'b1;
      ok_led <= ok_colour;
      rx_led <= rx_colour;
      tx_led <= tx_colour;
    end
  end
  // ==========================================================
  // alarm record and read port
  // ==========================================================
  reg [3:0] alarm_type;
  always @*
  begin
    alarm_type = 4'h0;
    if (status[`ST_LOS])
      alarm_type = 4'h1;
    else if (status[`ST_LOF])
      alarm_type = 4'h2;
    else if (status[`ST_AIS])
      alarm_type = 4'h3;
    else if (status[`ST_RAI])
      alarm_type = 4'h4;
    else if (status[`ST_SIG_LOS])
      alarm_type = 4'h5;
    else if (status[`ST_RMA])
      alarm_type = 4'h6;
    else if (status[`ST_SIG_AIS])
      alarm_type = 4'h7;
  end
  // card, type, slot, port, severity (0 minor)
  reg [31:0] record;
  always @(posedge clk)
  begin
    if (!reset_n)
      record <= 32'h0000_0000;
    else
      record <= {17'h0_0000, `CARD_TYPE_CODE, alarm_type, SLOT_ID,
        PORT_ID, 1'b0};
  end
  always @(posedge clk)
  begin
    if (!reset_n)
      rdata <= 32'h0000_0000;
    else if (rd)
    begin
      case (addr)
        `ADDR_CONTROL: rdata <= control;
        `ADDR_PORT_STATUS: rdata <= {23'h00_0000, status};
        `ADDR_PANEL: rdata <= {26'h000_0000, tx_led, rx_led, ok_led};
        `ADDR_LATCHED: rdata <= {29'h0000_0000, default_alarm,
          backup_alarm, switched_alarm};
        `ADDR_RECORD: rdata <= record;
        `ADDR_SYS_ALARM: rdata <= {24'h00_0000, sys_alarm};
        `ADDR_RADIO_ALARM: rdata <= {16'h0000, radio_alarm};
        default: rdata <= 32'h0000_0000;
      endcase
    end
    else
      rdata <= 32'h0000_0000;
  end
endmodule // port_alarm_monitor

// File: port_alarm_regs.vh
// register map, field positions and timing constants of the port alarm monitor
`ifndef PORT_ALARM_REGS_VH
`define PORT_ALARM_REGS_VH
`define ADDR_CONTROL 4'h0
`define ADDR_PORT_STATUS 4'h1
`define ADDR_PANEL 4'h2
`define ADDR_LATCHED 4'h3
`define ADDR_RECORD 4'h4
`define ADDR_SYS_ALARM 4'h5
`define ADDR_RADIO_ALARM 4'h6
`define ADDR_COMMAND 4'h7
`define CTRL_RESET 32'h0000_0000
`define CTRL_FRAMED 0
`define CTRL_T1 1
`define CTRL_PCM30 2
`define CTRL_LOOPBACK 3
`define CMD_CLEAR_SWITCHED 0
`define CMD_CLEAR_ALL 1
`define CMD_CLEAR_IMAGE 2
`define ST_LOS 0
`define ST_LOF 1
`define ST_AIS 2
`define ST_RAI 3
`define ST_SIG_LOS 4
`define ST_RMA 5
`define ST_SIG_AIS 6
`define ST_TX_AIS 7
`define ST_TX_SIG_AIS 8
`define COLOUR_OFF 2'h0
`define COLOUR_GREEN 2'h1
`define COLOUR_ORANGE 2'h2
`define COLOUR_RED 2'h3
`define FLASH_TIME_MS 250
`define CLK_KHZ 10000
`define FLASH_CYCLES (`FLASH_TIME_MS * `CLK_KHZ)
`define CARD_TYPE_CODE 4'h1
`define BOOT_SETTLE 2'h2
`define BOOT_DONE 2'h3
`endif

// File: sync2.v
// two flip-flop synchroniser for an asynchronous level
`timescale 1ns/1ps
module sync2 #(
  parameter WIDTH = 1
) (
  input wire clk,
  input wire reset_n,
  input wire [WIDTH-1:0] async_in,
  output reg [WIDTH-1:0] sync_out
);
  reg [WIDTH-1:0] stage;
  always @(posedge clk)
  begin
    if (!reset_n)
    begin
      stage <= {WIDTH{1'b0}};
      sync_out <= {WIDTH{1'b0}};
    end
    else
    begin
      stage <= async_in;
      sync_out <= stage;
    end
  end
endmodule // sync2

// File: colour_pick.v
// severity to indicator colour, major ahead of minor
`timescale 1ns/1ps
`include "port_alarm_regs.vh"
module colour_pick (
  input wire major,
  input wire minor,
  input wire [1:0] idle_colour,
  output reg [1:0] colour
);
  always @*
  begin
    if (major)
      colour = `COLOUR_RED;
    else if (minor)
      colour = `COLOUR_ORANGE;
    else
      colour = idle_colour;
  end
endmodule // colour_pick

// File: far_end_model.sv
// downstream e1/t1 framer as seen at the port receive input
`timescale 1ns/1ps
module far_end_model (
  input wire [6:0] cond,
  output wire line_signal_valid,
  output wire frame_align_found,
  output wire ais_pattern_rx,
  output wire remote_alarm_bit,
  output wire signalling_valid,
  output wire multiframe_bit6,
  output wire signalling_all_ones
);
  // ==========
  // receive path toward the port
  assign line_signal_valid = cond[6];
  assign frame_align_found = cond[6] && cond[5];
  assign ais_pattern_rx = cond[4];
  // raised while it has lost our signal or frame
  assign remote_alarm_bit = cond[3];
  assign signalling_valid = cond[2];
  // raised while it has lost signalling slot
  assign multiframe_bit6 = cond[1];
  assign signalling_all_ones = cond[0];
endmodule // far_end_model

// File: alarm_checker.sv
// concurrent checks on the port alarm monitor ports
`timescale 1ns/1ps
`include "port_alarm_regs.vh"
module alarm_checker (
  input wire clk,
  input wire reset_n,
  input wire [3:0] addr,
  input wire [31:0] wdata,
  input wire wr,
  input wire rd,
  input wire [31:0] rdata,
  input wire line_signal_valid,
  input wire ais_pattern_rx,
  input wire frame_align_found,
  input wire upstream_traffic_ok,
  input wire switchover_event,
  input wire tx_ais,
  input wire yellow_led,
  input wire [1:0] ok_led,
  input wire [1:0] rx_led,
  input wire [1:0] tx_led
);
  // clear all blanks the status for one cycle
  wire clear_all_wr = wr && (addr == `ADDR_COMMAND) &&
    wdata[`CMD_CLEAR_ALL];
  // ==========
  // assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  a_yellow_on: assert property (
    (!line_signal_valid || ais_pattern_rx)[*8] |->
    yellow_led || $past(clear_all_wr, 2))
    else $error("yellow led dark");
  a_yellow_off: assert property (
    (line_signal_valid && frame_align_found && !ais_pattern_rx)[*8]
    |-> !yellow_led) else $error("yellow led lit");
  a_ais_send: assert property (
    !upstream_traffic_ok[*8] |-> tx_ais) else $error("no ais sent");
  a_sys_red: assert property (
    wr && addr == `ADDR_SYS_ALARM && wdata[1] |-> ##[1:3] ok_led == 2'h3)
    else $error("ok led not red");
  a_rx_red: assert property (
    wr && addr == `ADDR_RADIO_ALARM && wdata[2] |-> ##[1:3] rx_led == 2'h3)
    else $error("rx led not red");
  a_tx_red: assert property (
    wr && addr == `ADDR_RADIO_ALARM && wdata[12] |-> ##[1:3] tx_led == 2'h3)
    else $error("tx led not red");
  a_switch_orange: assert property (
    switchover_event ##1 switchover_event |-> ##[1:6] ok_led[1])
    else $error("switchover not shown");
  a_rdata_idle: assert property (
    !rd |=> rdata == 32'h0000_0000) else $error("rdata not idle");
endmodule // alarm_checker
bind port_alarm_monitor alarm_checker chk_u (.clk(clk), .reset_n(reset_n),
  .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
  .line_signal_valid(line_signal_valid), .ais_pattern_rx(ais_pattern_rx),
  .frame_align_found(frame_align_found), .tx_ais(tx_ais),
  .upstream_traffic_ok(upstream_traffic_ok), .yellow_led(yellow_led),
  .switchover_event(switchover_event), .ok_led(ok_led), .rx_led(rx_led),
  .tx_led(tx_led));

// File: test_port_alarm_monitor.sv
// self-checking bench for the port alarm monitor
`timescale 1ns/1ps
`include "port_alarm_regs.vh"
`define chk(n,e,g) begin n_checks++; if ((g) !== (e)) begin error_cnt++; \
  $display("ERROR %s exp %h got %h", n, e, g); end end
module test_port_alarm_monitor;
  typedef struct packed {logic [3:0] c; logic [8:0] i, s; logic y;} row_t;
  row_t rows [13];
  logic clk = 0, reset_n = 0, wr = 0, rd = 0, sw = 0, bk = 1, df = 0, lo, hi;
  logic [3:0] addr = 0;
  logic [31:0] wdata = 0, rdata, d;
  logic [8:0] cond = 9'h193;
  logic [15:0] rv [6] = '{16'h0101, 16'h0202, 16'h0404, 16'h0808,
    16'h1101, 16'h2002};
  logic [3:0] re [6] = '{4'ha, 4'ha, 4'he, 4'he, 4'hb, 4'hb};
  logic tx_ais, tx_signalling_ais, yellow_led, green_led;
  logic [1:0] ok_led, rx_led, tx_led;
  logic lsv, faf, apr, rab, sgv, mfb, sao;
  int error_cnt = 0, n_checks = 0, i;
  far_end_model far_u (.cond(cond[8:2]), .line_signal_valid(lsv),
    .frame_align_found(faf), .ais_pattern_rx(apr), .remote_alarm_bit(rab),
    .signalling_valid(sgv), .multiframe_bit6(mfb),
    .signalling_all_ones(sao));
  port_alarm_monitor #(.FLASH_CYCLES(4), .SLOT_ID(4'h5), .PORT_ID(2'h2))
  dut_u (.clk(clk), .reset_n(reset_n), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .line_signal_valid(lsv),
    .frame_align_found(faf), .ais_pattern_rx(apr), .remote_alarm_bit(rab),
    .signalling_valid(sgv), .multiframe_bit6(mfb),
    .signalling_all_ones(sao), .upstream_traffic_ok(cond[1]),
    .signalling_stream_ok(cond[0]), .switchover_event(sw),
    .boot_backup_table(bk), .boot_default_table(df), .tx_ais(tx_ais),
    .tx_signalling_ais(tx_signalling_ais), .yellow_led(yellow_led),
    .green_led(green_led), .ok_led(ok_led), .rx_led(rx_led),
    .tx_led(tx_led));
  always #50 clk = ~clk;
  // ==========
  // bus and helper tasks
  task automatic wr_reg(input logic [3:0] a, input logic [31:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [3:0] a);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic watch_green;
    lo = 0;
    hi = 0;
    repeat (12)
    begin
      @(posedge clk);
      #1;
      if (green_led === 1'b0) lo = 1;
      if (green_led === 1'b1) hi = 1;
    end
  endtask
  task automatic tally_and_finish;
    if (error_cnt == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (3000) @(posedge clk);
    error_cnt++;
    tally_and_finish;
  end
  // ==========
  // tests
  initial
  begin
    rows[0] = '{4'h1, 9'h193, 9'h000, 1'b0};
    rows[1] = '{4'h1, 9'h053, 9'h001, 1'b1};
    rows[2] = '{4'h1, 9'h153, 9'h002, 1'b1};
    rows[3] = '{4'h0, 9'h153, 9'h004, 1'b1};
    rows[4] = '{4'h1, 9'h1b3, 9'h008, 1'b0};
    rows[5] = '{4'h3, 9'h113, 9'h002, 1'b1};
    rows[6] = '{4'h5, 9'h183, 9'h010, 1'b0};
    rows[7] = '{4'h5, 9'h19b, 9'h020, 1'b0};
    rows[8] = '{4'h5, 9'h197, 9'h040, 1'b0};
    rows[9] = '{4'h1, 9'h191, 9'h080, 1'b0};
    rows[10] = '{4'h5, 9'h192, 9'h100, 1'b0};
    rows[11] = '{4'h1, 9'h183, 9'h000, 1'b0};
    rows[12] = '{4'h7, 9'h183, 9'h000, 1'b0};
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    repeat (4) @(posedge clk);
    rd_reg(`ADDR_CONTROL);
    `chk("control", `CTRL_RESET, d)
    rd_reg(`ADDR_LATCHED);
    `chk("boot", 32'h0000_0002, d)
    for (i = 0; i < 13; i++)
    begin
      wr_reg(`ADDR_CONTROL, {28'h0, rows[i].c});
      cond <= rows[i].i;
      repeat (8) @(posedge clk);
      rd_reg(`ADDR_PORT_STATUS);
      `chk("status", {23'h0, rows[i].s}, d)
      `chk("tx_ais", rows[i].s[7], tx_ais)
      `chk("tx_sig_ais", rows[i].s[8], tx_signalling_ais)
      `chk("yellow", rows[i].y, yellow_led)
    end
    wr_reg(`ADDR_COMMAND, 32'h0000_0004);
    rd_reg(`ADDR_LATCHED);
    `chk("clr img", 32'h0000_0000, d)
    `chk("ok", `COLOUR_GREEN, ok_led)
    @(posedge clk) sw <= 1'b1;
    repeat (3) @(posedge clk);
    sw <= 1'b0;
    repeat (20) @(posedge clk);
    rd_reg(`ADDR_LATCHED);
    `chk("switched", 32'h0000_0001, d)
    `chk("ok", `COLOUR_ORANGE, ok_led)
    wr_reg(`ADDR_COMMAND, 32'h0000_0001);
    rd_reg(`ADDR_LATCHED);
    `chk("clr sw", 32'h0000_0000, d)
    `chk("ok", `COLOUR_GREEN, ok_led)
    wr_reg(`ADDR_SYS_ALARM, 32'h0000_0003);
    rd_reg(`ADDR_PANEL);
    `chk("ok", `COLOUR_RED, ok_led)
    wr_reg(`ADDR_SYS_ALARM, 32'h0000_0001);
    rd_reg(`ADDR_PANEL);
    `chk("ok", `COLOUR_ORANGE, ok_led)
    wr_reg(`ADDR_SYS_ALARM, 32'h0000_0000);
    for (i = 0; i < 6; i++)
    begin
      wr_reg(`ADDR_RADIO_ALARM, {16'h0000, rv[i]});
      rd_reg(`ADDR_PANEL);
      `chk("rx", re[i][3:2], rx_led)
      `chk("tx", re[i][1:0], tx_led)
      `chk("panel", {re[i][1:0], re[i][3:2]}, d[5:2])
    end
    wr_reg(`ADDR_RADIO_ALARM, 32'h0000_0000);
    wr_reg(4'hf, 32'hffff_ffff);
    rd_reg(4'hf);
    `chk("unmapped", 32'h0000_0000, d)
    wr_reg(`ADDR_CONTROL, 32'h0000_0009);
    watch_green;
    `chk("flash", 2'b11, {lo, hi})
    wr_reg(`ADDR_CONTROL, 32'h0000_0001);
    repeat (2) @(posedge clk);
    watch_green;
    `chk("steady", 2'b01, {lo, hi})
    @(posedge clk) cond <= 9'h051;
    sw <= 1'b1;
    repeat (8) @(posedge clk);
    sw <= 1'b0;
    rd_reg(`ADDR_RECORD);
    `chk("card", `CARD_TYPE_CODE, d[14:11])
    `chk("slot port", 6'h16, d[6:1])
    `chk("type", 4'h1, d[10:7])
    `chk("severity", 1'b0, d[0])
    wr_reg(`ADDR_COMMAND, 32'h0000_0002);
    rd_reg(`ADDR_LATCHED);
    `chk("clr all", 32'h0000_0000, d)
    repeat (8) @(posedge clk);
    rd_reg(`ADDR_PORT_STATUS);
    `chk("relive", 32'h0000_0081, d)
    @(posedge clk) reset_n <= 1'b0;
    df <= 1'b1;
    bk <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    `chk("quiet", 3'b000, {tx_ais, yellow_led, green_led})
    @(posedge clk) reset_n <= 1'b1;
    repeat (6) @(posedge clk);
    rd_reg(`ADDR_LATCHED);
    `chk("boot dflt", 32'h0000_0004, d)
    tally_and_finish;
  end
endmodule // test_port_alarm_monitor
